// File: verilog/tcmdc_pkg.sv
// Purpose: constants shared by the tandem connection monitor sink block
// Assumes: 32-bit APB register words, four byte addresses per register word
// Notes: overhead byte bit 1 is the msb, so bit n sits at index 8-n
package tcmdc_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DEG_CFG = 8'h04;
    localparam logic [7:0] A_DEFECTS = 8'h08;
    localparam logic [7:0] A_INT_STATUS = 8'h0c;
    localparam logic [7:0] A_INT_MASK = 8'h10;
    localparam logic [7:0] A_NEAR_EBC = 8'h14;
    localparam logic [7:0] A_FAR_EBC = 8'h18;
    localparam logic [7:0] A_OUT_EBC = 8'h1c;
    localparam logic [7:0] A_SECONDS = 8'h20;
    localparam logic [7:0] A_EXP_TRACE = 8'h24;
    localparam int CTRL_MONITOR = 0;
    localparam int CTRL_TRACE_DIS = 1;
    localparam int CTRL_SRV_REP_EN = 2;
    localparam int CTRL_REMOTE_REP_EN = 3;
    localparam int CTRL_OUT_REP_EN = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [19:0] DEG_CFG_RESET = 20'h30010;
    localparam int REP_UNEQ = 0;
    localparam int REP_LOSS = 1;
    localparam int REP_TRACE = 2;
    localparam int REP_DEG = 3;
    localparam int REP_SRV = 4;
    localparam int REP_REMOTE = 5;
    localparam int REP_OUT = 6;
    localparam int NUM_REP = 7;
    localparam int EBC_W = 32;
    localparam logic [15:0] FAS_PATTERN = 16'hfffe;
    localparam logic [6:0] FAS_LAST = 7'h07;
    localparam logic [6:0] TRACE_FIRST = 7'h08;
    localparam logic [6:0] TRACE_LAST = 7'h47;
    localparam logic [6:0] REMOTE_FRAME = 7'h48;
    localparam logic [6:0] OUTGOING_FRAME = 7'h49;
    localparam logic [6:0] MF_LAST = 7'h4b;
    localparam logic [1:0] FAS_LOSS = 2'h2;
    localparam logic [1:0] TRACE_PERSIST = 2'h3;
    localparam int UNEQ_PERSIST = 5;
    localparam int REMOTE_PERSIST = 5;
    localparam logic [3:0] IEC_MAX = 4'h8;
    typedef enum logic [0:0] {
        ST_OUT_OF_MULTIFRAME = 1'b0,
        ST_IN_MULTIFRAME = 1'b1
    } tcmdc_mf_t;
endpackage

// File: verilog/tcmdc_pm_if.sv
// Purpose: carries per-frame events to the one-second counter and results back
// Assumes: all signals on the block clock
// Notes: results change only on the one-second strobe
`timescale 1ns/1ps
interface tcmdc_pm_if;
    import tcmdc_pkg::*;
    logic second;
    logic near_fail;
    logic far_def;
    logic out_def;
    logic near_blk;
    logic far_blk;
    logic out_blk;
    logic [EBC_W-1:0] near_cnt;
    logic [EBC_W-1:0] far_cnt;
    logic [EBC_W-1:0] out_cnt;
    logic [2:0] seconds;
    modport source(output second, near_fail, far_def, out_def, near_blk, far_blk, out_blk,
        input near_cnt, far_cnt, out_cnt, seconds);
    modport counter(input second, near_fail, far_def, out_def, near_blk, far_blk, out_blk,
        output near_cnt, far_cnt, out_cnt, seconds);
endinterface

// File: verilog/tcmdc_persist.sv
// Purpose: declares or clears a defect after a run of agreeing samples
// Assumes: i_sample_valid is a one-cycle strobe per sample
// Notes: a disagreeing sample restarts the run
`timescale 1ns/1ps
module tcmdc_persist
    import tcmdc_pkg::*;
#(
    parameter int COUNT = 5
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sample_valid,
    input wire logic i_sample,
    output logic o_defect
);
    typedef struct packed {
        logic defect;
        logic [3:0] cnt;
    } tcmdc_persist_t;
    tcmdc_persist_t st;
    tcmdc_persist_t next_st;
    always_comb
    begin
        next_st = st;
        if (i_sample_valid)
        begin
            if (i_sample == st.defect)
                next_st.cnt = 4'h0;
            else if (st.cnt == 4'(COUNT - 1))
            begin
                next_st.defect = i_sample;
                next_st.cnt = 4'h0;
            end
            else
                next_st.cnt = st.cnt + 4'h1;
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st <= '0;
        else
            st <= next_st;
    end
    assign o_defect = st.defect;
    a_change_needs_sample: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $changed(o_defect) |-> $past(i_sample_valid) && $past(i_sample) == o_defect)
        else $error("defect changed without an agreeing sample");
endmodule // tcmdc_persist

// File: verilog/tcmdc_pm.sv
// Purpose: one-second defect seconds and errored block sums
// Assumes: pm.second is a one-cycle strobe
// Notes: an event in the strobe cycle is counted into the closing second
`timescale 1ns/1ps
module tcmdc_pm
    import tcmdc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    tcmdc_pm_if.counter pm
);
    typedef struct packed {
        logic [EBC_W-1:0] acc_n;
        logic [EBC_W-1:0] acc_f;
        logic [EBC_W-1:0] acc_o;
        logic [EBC_W-1:0] cnt_n;
        logic [EBC_W-1:0] cnt_f;
        logic [EBC_W-1:0] cnt_o;
        logic [2:0] seen;
        logic [2:0] sec;
    } tcmdc_pm_state_t;
    tcmdc_pm_state_t st;
    tcmdc_pm_state_t next_st;
    logic [EBC_W-1:0] sum_n;
    logic [EBC_W-1:0] sum_f;
    logic [EBC_W-1:0] sum_o;
    logic [2:0] seen_now;
    assign sum_n = st.acc_n + EBC_W'(pm.near_blk);
    assign sum_f = st.acc_f + EBC_W'(pm.far_blk);
    assign sum_o = st.acc_o + EBC_W'(pm.out_blk);
    assign seen_now = st.seen | {pm.out_def, pm.far_def, pm.near_fail};
    always_comb
    begin
        next_st = st;
        next_st.acc_n = sum_n;
        next_st.acc_f = sum_f;
        next_st.acc_o = sum_o;
        next_st.seen = seen_now;
        if (pm.second)
        begin
            next_st.cnt_n = sum_n;
            next_st.cnt_f = sum_f;
            next_st.cnt_o = sum_o;
            next_st.sec = seen_now;
            next_st.acc_n = '0;
            next_st.acc_f = '0;
            next_st.acc_o = '0;
            next_st.seen = 3'h0;
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st <= '0;
        else
            st <= next_st;
    end
    assign pm.near_cnt = st.cnt_n;
    assign pm.far_cnt = st.cnt_f;
    assign pm.out_cnt = st.cnt_o;
    assign pm.seconds = st.sec;
    a_second_marks: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        pm.second && pm.near_fail |=> pm.seconds[0] && st.seen == 3'h0)
        else $error("near defect second not marked");
endmodule // tcmdc_pm

// File: verilog/tcmdc_monitor.sv
// Purpose: tandem connection monitor sink: defects, correlation, performance
// Assumes: frame inputs and the one-second strobe are on i_clk
// Notes: one frame per i_frame_start; APB answers with zero wait states
// Operation
// - trace mismatch settles within one second
// - server fail forces trace mismatch off
// - management disable keeps trace mismatch off
// - degrade from per-frame parity violation counts
// - remote defect from multiframed remote bit
// - outgoing defect from multiframed outgoing bit
// - trail fail and degrade from defects
// - report unequipped; loss only without unequipped
// - trace report needs no unequipped, loss
// - degrade report needs no trace, loss
// - server fail report needs enable
// - remote report gated by enable, defects
// - outgoing report gated by enable, defects
// - per-second defect seconds and block sums
// - unequipped after five zero bytes, both ways
// - loss of connection while out of multiframe
// - search fifteen ones then zero pattern
// - lose after two bad patterns, regain one
`timescale 1ns/1ps
module tcmdc_monitor
    import tcmdc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_frame_start,
    input wire logic [7:0] i_tc_byte,
    input wire logic [3:0] i_bip_count,
    input wire logic i_incoming_server_fail,
    input wire logic i_one_second,
    output logic o_trail_signal_fail,
    output logic o_trail_signal_degrade,
    output logic o_irq
);
    typedef struct packed {
        tcmdc_mf_t mf;
        logic [6:0] mf_cnt;
        logic [15:0] fas_sr;
        logic [1:0] fas_err;
        logic trace_diff;
        logic tim;
        logic [1:0] tim_cnt;
        logic [15:0] deg_acc;
        logic [3:0] deg_cnt;
        logic deg;
        logic tsf;
        logic tsd;
        logic irq;
        logic [4:0] ctrl;
        logic [19:0] deg_cfg;
        logic [127:0] exp_trace;
        logic [NUM_REP-1:0] int_status;
        logic [NUM_REP-1:0] int_mask;
        logic [NUM_REP-1:0] prev_rep;
        logic [31:0] rdata;
    } tcmdc_state_t;
    localparam tcmdc_state_t ST_RESET = '{mf: ST_OUT_OF_MULTIFRAME, ctrl: CTRL_RESET,
        deg_cfg: DEG_CFG_RESET, default: '0};

    tcmdc_state_t st;
    tcmdc_state_t next_st;
    tcmdc_pm_if pm_bus();

    logic [15:0] new_sr;
    logic [6:0] trace_idx;
    logic [127:0] exp_shift;
    logic pair_diff;
    logic in_mf;
    logic ltc;
    logic uneq;
    logic rdi;
    logic odi;
    logic mon;
    logic tsf_now;
    logic [3:0] iec;
    logic [3:0] iec_eff;
    logic [16:0] deg_sum;
    logic deg_bad;
    logic [NUM_REP-1:0] rep;
    logic [NUM_REP-1:0] w1c;
    logic apb_setup;
    logic apb_write;
    logic [31:0] rd_data;
    logic rd_hit;

    assign new_sr = {st.fas_sr[13:0], i_tc_byte[1:0]};
    assign trace_idx = st.mf_cnt - TRACE_FIRST;
    assign exp_shift = st.exp_trace >> {trace_idx, 1'b0};
    assign pair_diff = exp_shift[1:0] != i_tc_byte[1:0];
    assign in_mf = st.mf == ST_IN_MULTIFRAME;
    assign ltc = !in_mf;
    assign mon = st.ctrl[CTRL_MONITOR];
    assign iec = i_tc_byte[7:4];
    // codes above eight carry no error count
    assign iec_eff = (iec > IEC_MAX) ? 4'h0 : iec;
    assign deg_sum = {1'b0, st.deg_acc} + {13'h0, i_bip_count};
    assign deg_bad = st.deg_acc >= st.deg_cfg[15:0];
    assign tsf_now = i_incoming_server_fail | uneq | st.tim | ltc;

    tcmdc_persist #(
        .COUNT(UNEQ_PERSIST)
    ) u_uneq (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_sample_valid(i_frame_start),
        .i_sample(i_tc_byte == 8'h00),
        .o_defect(uneq)
    );

    tcmdc_persist #(
        .COUNT(REMOTE_PERSIST)
    ) u_remote (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_sample_valid(i_frame_start && in_mf && st.mf_cnt == REMOTE_FRAME),
        .i_sample(i_tc_byte[0]),
        .o_defect(rdi)
    );

    tcmdc_persist #(
        .COUNT(REMOTE_PERSIST)
    ) u_outgoing (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_sample_valid(i_frame_start && in_mf && st.mf_cnt == OUTGOING_FRAME),
        .i_sample(i_tc_byte[1]),
        .o_defect(odi)
    );

    assign pm_bus.second = i_one_second;
    assign pm_bus.near_fail = st.tsf;
    assign pm_bus.far_def = rdi;
    assign pm_bus.out_def = odi;
    assign pm_bus.near_blk = i_frame_start && (i_bip_count != iec_eff);
    // remote error bits mean nothing until the multiframe is found
    assign pm_bus.far_blk = i_frame_start && in_mf && i_tc_byte[3];
    assign pm_bus.out_blk = i_frame_start && in_mf && i_tc_byte[2];

    tcmdc_pm u_pm (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .pm(pm_bus.counter)
    );

    assign rep[REP_UNEQ] = mon & uneq;
    assign rep[REP_LOSS] = mon & ~uneq & ltc;
    assign rep[REP_TRACE] = mon & ~uneq & ~ltc & st.tim;
    assign rep[REP_DEG] = mon & ~st.tim & ~ltc & st.deg;
    assign rep[REP_SRV] = mon & i_incoming_server_fail & st.ctrl[CTRL_SRV_REP_EN];
    assign rep[REP_REMOTE] = mon & ~uneq & ~st.tim & ~ltc & rdi
        & st.ctrl[CTRL_REMOTE_REP_EN];
    assign rep[REP_OUT] = mon & ~uneq & ~st.tim & ~ltc & odi
        & st.ctrl[CTRL_OUT_REP_EN];

    assign apb_setup = i_psel && !i_penable;
    assign apb_write = i_psel && i_penable && i_pwrite;
    assign w1c = (apb_write && i_paddr == A_INT_STATUS) ? i_pwdata[NUM_REP-1:0] : '0;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_data = 32'h0;
        case (i_paddr)
            A_CTRL: rd_data = {27'h0, st.ctrl};
            A_DEG_CFG: rd_data = {12'h0, st.deg_cfg};
            A_DEFECTS: rd_data = {17'h0, rep, 1'b0, i_incoming_server_fail, odi, rdi,
                st.deg, st.tim, ltc, uneq};
            A_INT_STATUS: rd_data = {25'h0, st.int_status};
            A_INT_MASK: rd_data = {25'h0, st.int_mask};
            A_NEAR_EBC: rd_data = pm_bus.near_cnt;
            A_FAR_EBC: rd_data = pm_bus.far_cnt;
            A_OUT_EBC: rd_data = pm_bus.out_cnt;
            A_SECONDS: rd_data = {29'h0, pm_bus.seconds};
            A_EXP_TRACE: rd_data = st.exp_trace[31:0];
            A_EXP_TRACE + 8'h04: rd_data = st.exp_trace[63:32];
            A_EXP_TRACE + 8'h08: rd_data = st.exp_trace[95:64];
            A_EXP_TRACE + 8'h0c: rd_data = st.exp_trace[127:96];
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        next_st = st;
        if (i_frame_start)
        begin
            next_st.fas_sr = new_sr;
            next_st.deg_acc = deg_sum[16] ? 16'hffff : deg_sum[15:0];
            if (!in_mf)
            begin
                // search shifts one bit pair per frame
                if (new_sr == FAS_PATTERN)
                begin
                    next_st.mf = ST_IN_MULTIFRAME;
                    next_st.mf_cnt = TRACE_FIRST;
                    next_st.fas_err = 2'h0;
                    next_st.trace_diff = 1'b0;
                end
            end
            else
            begin
                next_st.mf_cnt = (st.mf_cnt == MF_LAST) ? 7'h00 : st.mf_cnt + 7'h01;
                if (st.mf_cnt == FAS_LAST)
                begin
                    if (new_sr == FAS_PATTERN)
                        next_st.fas_err = 2'h0;
                    else if (st.fas_err + 2'h1 == FAS_LOSS)
                    begin
                        next_st.mf = ST_OUT_OF_MULTIFRAME;
                        next_st.fas_err = 2'h0;
                    end
                    else
                        next_st.fas_err = st.fas_err + 2'h1;
                end
                if (st.mf_cnt >= TRACE_FIRST && st.mf_cnt < TRACE_LAST)
                    next_st.trace_diff = st.trace_diff | pair_diff;
                if (st.mf_cnt == TRACE_LAST)
                begin
                    next_st.trace_diff = 1'b0;
                    // a few multiframes of agreement, far below one second
                    if ((st.trace_diff | pair_diff) == st.tim)
                        next_st.tim_cnt = 2'h0;
                    else if (st.tim_cnt == TRACE_PERSIST - 2'h1)
                    begin
                        next_st.tim = ~st.tim;
                        next_st.tim_cnt = 2'h0;
                    end
                    else
                        next_st.tim_cnt = st.tim_cnt + 2'h1;
                end
            end
        end
        if (i_incoming_server_fail || st.ctrl[CTRL_TRACE_DIS])
        begin
            next_st.tim = 1'b0;
            next_st.tim_cnt = 2'h0;
        end
        if (i_one_second)
        begin
            next_st.deg_acc = i_frame_start ? {12'h0, i_bip_count} : 16'h0;
            if (deg_bad == st.deg)
                next_st.deg_cnt = 4'h0;
            else if (st.deg_cnt + 4'h1 >= st.deg_cfg[19:16])
            begin
                next_st.deg = deg_bad;
                next_st.deg_cnt = 4'h0;
            end
            else
                next_st.deg_cnt = st.deg_cnt + 4'h1;
        end
        next_st.tsf = tsf_now;
        next_st.tsd = st.deg;
        // a new report wins over a clear in the same cycle
        next_st.prev_rep = rep;
        next_st.int_status = (st.int_status & ~w1c) | (rep & ~st.prev_rep);
        next_st.irq = |(st.int_status & st.int_mask);
        if (apb_setup)
            next_st.rdata = rd_data;
        if (apb_write)
        begin
            case (i_paddr)
                A_CTRL: next_st.ctrl = i_pwdata[4:0];
                A_DEG_CFG: next_st.deg_cfg = i_pwdata[19:0];
                A_INT_MASK: next_st.int_mask = i_pwdata[NUM_REP-1:0];
                A_EXP_TRACE: next_st.exp_trace[31:0] = i_pwdata;
                A_EXP_TRACE + 8'h04: next_st.exp_trace[63:32] = i_pwdata;
                A_EXP_TRACE + 8'h08: next_st.exp_trace[95:64] = i_pwdata;
                A_EXP_TRACE + 8'h0c: next_st.exp_trace[127:96] = i_pwdata;
                default: next_st.rdata = st.rdata;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    assign o_prdata = st.rdata;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !rd_hit;
    assign o_trail_signal_fail = st.tsf;
    assign o_trail_signal_degrade = st.tsd;
    assign o_irq = st.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_trace_srv_quiet: assert property (i_incoming_server_fail |=> !st.tim)
        else $error("trace mismatch active under server fail");
    a_trace_disable: assert property (st.ctrl[CTRL_TRACE_DIS] |=> !st.tim)
        else $error("trace mismatch active while disabled");
    a_trace_rise_end: assert property ($rose(st.tim) |->
        $past(i_frame_start && st.mf_cnt == TRACE_LAST && in_mf))
        else $error("trace mismatch rose away from multiframe end");
    // first edge after release still shows the reset value of the flop
    a_tsf_sources: assert property ($past(i_reset_n) |-> o_trail_signal_fail ==
        $past(i_incoming_server_fail | uneq | st.tim | ltc))
        else $error("trail signal fail does not follow defects");
    a_tsd_degrade: assert property ($past(i_reset_n) |->
        o_trail_signal_degrade == $past(st.deg))
        else $error("trail signal degrade does not follow degrade");
    a_mon_gates: assert property (!mon |-> rep == '0)
        else $error("report active while monitoring is off");
    a_loss_report: assert property (rep[REP_LOSS] |-> ltc && !uneq)
        else $error("loss reported with unequipped");
    a_trace_report: assert property (rep[REP_TRACE] |-> !uneq && !ltc)
        else $error("trace reported under higher defect");
    a_deg_report: assert property (rep[REP_DEG] |-> !st.tim && !ltc)
        else $error("degrade reported under higher defect");
    a_srv_report: assert property (rep[REP_SRV] |-> st.ctrl[CTRL_SRV_REP_EN])
        else $error("server fail reported while not enabled");
    a_remote_gate: assert property (rep[REP_REMOTE] |->
        st.ctrl[CTRL_REMOTE_REP_EN] && !uneq && !st.tim && !ltc)
        else $error("remote defect reported while gated");
    a_out_gate: assert property (rep[REP_OUT] |->
        st.ctrl[CTRL_OUT_REP_EN] && !uneq && !st.tim && !ltc)
        else $error("outgoing defect reported while gated");
    a_lock_pattern: assert property (!in_mf && i_frame_start && new_sr == FAS_PATTERN
        |=> in_mf && st.mf_cnt == TRACE_FIRST && !ltc)
        else $error("no lock on alignment pattern");
    a_loss_two_bad: assert property (in_mf && i_frame_start && st.mf_cnt == FAS_LAST
        && st.fas_err == 2'h1 && new_sr != FAS_PATTERN |=> ltc)
        else $error("alignment kept after two bad patterns");
    a_irq_level: assert property (##1 o_irq == $past(|(st.int_status & st.int_mask)))
        else $error("interrupt does not follow masked status");

    c_lock: cover property (!in_mf ##1 in_mf);
    c_trace_rise: cover property ($rose(st.tim));
    c_irq: cover property ($rose(o_irq));
    c_second_blocks: cover property (i_one_second && pm_bus.near_blk);
endmodule // tcmdc_monitor

// File: testbench/tcmdc_src_model.sv
// Purpose: upstream tandem source model, frames with multiframed overhead
// Assumes: one frame every four clocks
// Notes: lines carry changing junk between frames
`timescale 1ns/1ps
module tcmdc_src_model
    import tcmdc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_zero,
    input wire logic i_bad_fas,
    input wire logic i_remote,
    input wire logic i_outgoing,
    input wire logic i_blk_err,
    input wire logic [3:0] i_bip,
    input wire logic [127:0] i_trace,
    output logic o_frame_start,
    output logic [7:0] o_tc_byte,
    output logic [3:0] o_bip_count
);
    logic [1:0] cyc;
    logic [6:0] idx;
    logic [15:0] fas;
    logic [1:0] pair;
    always_comb
    begin
        fas = FAS_PATTERN ^ {15'h0, i_bad_fas};
        if (idx <= FAS_LAST)
            pair = fas[15 - 2 * idx -: 2];
        else if (idx <= TRACE_LAST)
            pair = i_trace[2 * (idx - TRACE_FIRST) +: 2];
        else if (idx == REMOTE_FRAME)
            pair = {1'b1, i_remote};
        else if (idx == OUTGOING_FRAME)
            pair = {i_outgoing, 1'b1};
        else
            pair = 2'h3;
    end
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cyc <= 2'h0;
            idx <= 7'h0;
            o_frame_start <= 1'b0;
            o_tc_byte <= 8'hff;
            o_bip_count <= 4'h0;
        end
        else
        begin
            cyc <= cyc + 2'h1;
            o_frame_start <= (cyc == 2'h3);
            // inverted junk so stale values never look valid
            o_tc_byte <= ~o_tc_byte;
            o_bip_count <= ~o_bip_count;
            if (cyc == 2'h3)
            begin
                idx <= (idx == MF_LAST) ? 7'h0 : idx + 7'h1;
                o_tc_byte <= i_zero ? 8'h00 : {4'h0, i_blk_err, i_blk_err, pair};
                o_bip_count <= i_bip;
            end
        end
    end
endmodule // tcmdc_src_model

// File: testbench/tcmdc_monitor_tb.sv
// Purpose: self-checking bench for the tandem monitor sink
// Assumes: source model on the frame inputs, APB master here
// Notes: read words are checked from a queue of expected values
`timescale 1ns/1ps
module tcmdc_monitor_tb;
    import tcmdc_pkg::*;
    localparam int MF = 304;
    logic i_clk = 1'b0, i_reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0, tc;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fs, tsf, tsd, irq;
    logic srv = 1'b0, sec = 1'b0, zero = 1'b0, bad = 1'b0, rem = 1'b0, outd = 1'b0, blk = 1'b0;
    logic [3:0] bip, bip_set = 4'h0;
    logic [127:0] trc, exp_trc;
    logic [32:0] exp_q[$];
    int n_errors = 0, cmp_count = 0, cycles = 0;
    always #2 i_clk = ~i_clk;
    tcmdc_monitor i_tcmdc_monitor (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_frame_start(fs),
        .i_tc_byte(tc), .i_bip_count(bip), .i_incoming_server_fail(srv), .i_one_second(sec),
        .o_trail_signal_fail(tsf), .o_trail_signal_degrade(tsd), .o_irq(irq));
    tcmdc_src_model i_tcmdc_src_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_zero(zero),
        .i_bad_fas(bad), .i_remote(rem), .i_outgoing(outd), .i_blk_err(blk), .i_bip(bip_set),
        .i_trace(trc), .o_frame_start(fs), .o_tc_byte(tc), .o_bip_count(bip));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do
            @(posedge i_clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    always @(posedge i_clk)
        if (psel && penable && !pwrite && pready === 1'b1)
            chk({pslverr, prdata}, exp_q.pop_front());
    task automatic frames(input int n);
        repeat (n) @(posedge i_clk iff fs);
    endtask
    task automatic mfs(input int n);
        repeat (n * MF) @(posedge i_clk);
    endtask
    task automatic second_pulse;
        @(posedge i_clk);
        sec <= 1'b1;
        @(posedge i_clk);
        sec <= 1'b0;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(32'h47702ab3));
        // low bit of each pair set, so trace frames are never all zero
        trc = {$urandom, $urandom, $urandom, $urandom} | {4{32'h55555555}};
        exp_trc = trc;
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(A_CTRL, 33'h0);
        rd(A_DEG_CFG, {13'h0, DEG_CFG_RESET});
        rd(A_INT_MASK, 33'h0);
        rd(8'h40, 33'h100000000);
        rd(A_DEFECTS, 33'h2);
        chk({32'h0, tsf}, 33'h1);
        for (int i = 0; i < 4; i++)
            apb(1'b1, A_EXP_TRACE + 8'(4 * i), exp_trc[32 * i +: 32]);
        apb(1'b1, A_CTRL, 32'h1d);
        mfs(3);
        rd(A_DEFECTS, 33'h0);
        chk({32'h0, tsf}, 33'h0);
        $display("test reset and lock done");
        apb(1'b1, A_DEG_CFG, 32'h10004);
        second_pulse();
        apb(1'b1, A_INT_STATUS, 32'h7f);
        frames(1);
        bip_set <= 4'h3;
        blk <= 1'b1;
        frames(2);
        bip_set <= 4'h0;
        blk <= 1'b0;
        second_pulse();
        rd(A_NEAR_EBC, 33'h2);
        rd(A_FAR_EBC, 33'h2);
        rd(A_OUT_EBC, 33'h2);
        rd(A_SECONDS, 33'h0);
        rd(A_DEFECTS, 33'h808);
        chk({32'h0, tsd}, 33'h1);
        rd(A_INT_STATUS, 33'h8);
        apb(1'b1, A_INT_MASK, 32'h8);
        repeat (2) @(posedge i_clk);
        chk({32'h0, irq}, 33'h1);
        apb(1'b1, A_INT_STATUS, 32'h8);
        repeat (2) @(posedge i_clk);
        chk({32'h0, irq}, 33'h0);
        second_pulse();
        rd(A_DEFECTS, 33'h0);
        $display("test counts and degrade done");
        trc[1] <= ~trc[1];
        mfs(4);
        rd(A_DEFECTS, 33'h404);
        chk({32'h0, tsf}, 33'h1);
        rd(A_INT_STATUS, 33'h4);
        apb(1'b1, A_CTRL, 32'h1f);
        rd(A_DEFECTS, 33'h0);
        apb(1'b1, A_CTRL, 32'h1d);
        srv <= 1'b1;
        rd(A_DEFECTS, 33'h1040);
        chk({32'h0, tsf}, 33'h1);
        trc <= exp_trc;
        srv <= 1'b0;
        mfs(4);
        rd(A_DEFECTS, 33'h0);
        $display("test trace and server fail done");
        rem <= 1'b1;
        outd <= 1'b1;
        mfs(6);
        rd(A_DEFECTS, 33'h6030);
        second_pulse();
        second_pulse();
        rd(A_SECONDS, 33'h6);
        apb(1'b1, A_CTRL, 32'h1c);
        rd(A_DEFECTS, 33'h30);
        apb(1'b1, A_CTRL, 32'h1d);
        $display("test remote and outgoing done");
        frames(1);
        zero <= 1'b1;
        frames(4);
        rd(A_DEFECTS, 33'h6030);
        frames(1);
        rd(A_DEFECTS, 33'h131);
        chk({32'h0, tsf}, 33'h1);
        zero <= 1'b0;
        rem <= 1'b0;
        outd <= 1'b0;
        frames(6);
        rd(A_DEFECTS, 33'h6030);
        mfs(6);
        rd(A_DEFECTS, 33'h0);
        $display("test unequipped done");
        bad <= 1'b1;
        mfs(3);
        rd(A_DEFECTS, 33'h202);
        bad <= 1'b0;
        mfs(2);
        rd(A_DEFECTS, 33'h0);
        $display("test multiframe loss done");
        summarize();
    end
endmodule // tcmdc_monitor_tb
